// [i2c_host_model.sv]
/*
 * Host-side two-wire master model driving the control port.
 * Assumes an open-drain sda with a pull-up and a 100 MHz reference clock.
 */
`timescale 1ns/1ns
`include "irq_power_params.svh"

module i2c_host_model (
	input  wire logic i_ref_clk, // reference clock
	input  wire logic i_sda_oe,  // device pulls sda
	output logic      o_scl,     // bus clock
	output wire logic o_sda      // resolved sda
);
	logic low_r = 1'b0;
	initial o_scl = 1'b1;
	// wired-and with pull-up, so a released line reads high, never stale
	assign o_sda = ~(low_r | i_sda_oe);
	task automatic q4();
		repeat (4) @(posedge i_ref_clk);
	endtask
	// sda first, scl four clocks later: keeps data away from scl edges
	task automatic edge_to(input logic l, input logic c);
		low_r <= l;
		q4();
		o_scl <= c;
		q4();
	endtask
	task automatic bit_io(input logic b, output logic s);
		edge_to(~b, 1'b1);
		s = o_sda;
		o_scl <= 1'b0;
		q4();
	endtask
	task automatic st();
		edge_to(1'b0, 1'b1);
		edge_to(1'b1, 1'b0);
	endtask
	task automatic sp();
		edge_to(1'b1, 1'b1);
		low_r <= 1'b0;
		q4();
	endtask
	task automatic xfer(input logic [7:0] d, input logic m, output logic [7:0] q);
		logic a;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], q[i]);
		bit_io(m, a);
	endtask
	task automatic wr(input logic [7:0] r, input logic [7:0] d);
		logic [7:0] q;
		st();
		xfer({`I2C_DEVICE_ADDR, 1'b0}, 1'b1, q);
		xfer(r, 1'b1, q);
		xfer(d, 1'b1, q);
		sp();
	endtask
	// single byte read ends with a nack, as the port expects
	task automatic rd(input logic [7:0] r, output logic [7:0] q);
		st();
		xfer({`I2C_DEVICE_ADDR, 1'b0}, 1'b1, q);
		xfer(r, 1'b1, q);
		st();
		xfer({`I2C_DEVICE_ADDR, 1'b1}, 1'b1, q);
		xfer(8'hFF, 1'b1, q);
		sp();
	endtask
endmodule

// [i2c_register_port.sv]
/*
 * Two-wire slave that turns bus transfers into register strobes.
 * Assumes scl and sda are already synchronous to i_ref_clk and that the
 * clock is much faster than scl.
 */
`timescale 1ns/1ns
`include "irq_power_params.svh"

module i2c_register_port #(
	parameter logic [6:0] DEVICE_ADDR = `I2C_DEVICE_ADDR
) (
	input  wire logic       i_ref_clk,  // system clock
	input  wire logic       i_reset,    // async reset, high
	input  wire logic       i_scl,      // bus clock level
	input  wire logic       i_sda,      // bus data level
	output logic            o_sda_out,  // driven level, always low
	output logic            o_sda_oe,   // high while pulling sda
	output logic            o_wr_stb,   // one-cycle write strobe
	output logic [7:0]      o_reg_addr, // current register pointer
	output logic [7:0]      o_wr_data,  // written byte
	input  wire logic [7:0] i_rd_data   // byte at o_reg_addr
);

	// addresses below the lowest legal one are reserved on the bus
	generate
		if (DEVICE_ADDR < `I2C_LOWEST_ADDR)
		begin : g_bad_addr
			$error("device address lies in the reserved range");
		end
	endgenerate

	// ------------------------------------------------------------------
	// bus conditions
	// ------------------------------------------------------------------
	logic                   scl_r;
	logic                   sda_r;
	irq_power_pkg::i2c_state_t state_r;
	logic [3:0]             bits_r;
	logic [7:0]             shift_r;
	logic                   rw_r;
	logic                   sda_oe_r;
	logic                   wr_stb_r;
	logic [7:0]             wr_data_r;
	logic [7:0]             addr_r;

	// start and stop are sda moves while scl stays high
	wire start_det = scl_r & i_scl & sda_r & ~i_sda;
	wire stop_det  = scl_r & i_scl & ~sda_r & i_sda;
	wire scl_rise  = ~scl_r & i_scl;
	wire scl_fall  = scl_r & ~i_scl;
	wire byte_done = (bits_r == `I2C_BYTE_BITS);
	wire addr_hit  = (shift_r[7:1] == DEVICE_ADDR);

	assign o_sda_out  = 1'b0;
	assign o_sda_oe   = sda_oe_r;
	assign o_wr_stb   = wr_stb_r;
	assign o_wr_data  = wr_data_r;
	assign o_reg_addr = addr_r;

	// ------------------------------------------------------------------
	// transfer sequencer
	// ------------------------------------------------------------------
	// sda changes only on scl falling so the master samples a stable bit
	always_ff @(posedge i_ref_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			scl_r     <= 1'b1;
			sda_r     <= 1'b1;
			state_r   <= irq_power_pkg::ST_IDLE;
			bits_r    <= 4'h0;
			shift_r   <= 8'h00;
			rw_r      <= 1'b0;
			sda_oe_r  <= 1'b0;
			wr_stb_r  <= 1'b0;
			wr_data_r <= 8'h00;
			addr_r    <= 8'h00;
		end
		else
		begin
			scl_r    <= i_scl;
			sda_r    <= i_sda;
			wr_stb_r <= 1'b0;
			if (start_det)
			begin
				state_r  <= irq_power_pkg::ST_ADDR;
				bits_r   <= 4'h0;
				sda_oe_r <= 1'b0;
			end
			else if (stop_det)
			begin
				state_r  <= irq_power_pkg::ST_IDLE;
				sda_oe_r <= 1'b0;
			end
			else
			begin
				case (state_r)
				irq_power_pkg::ST_ADDR, irq_power_pkg::ST_REG, irq_power_pkg::ST_WDATA:
				begin
					if (scl_rise)
					begin
						shift_r <= {shift_r[6:0], i_sda};
						bits_r  <= bits_r + 4'h1;
					end
					else if (scl_fall && byte_done)
					begin
						bits_r <= 4'h0;
						if (state_r == irq_power_pkg::ST_ADDR)
						begin
							rw_r     <= shift_r[0];
							sda_oe_r <= addr_hit;
							state_r  <= addr_hit ? irq_power_pkg::ST_ADDR_ACK
							                     : irq_power_pkg::ST_IDLE;
						end
						else if (state_r == irq_power_pkg::ST_REG)
						begin
							addr_r   <= shift_r;
							sda_oe_r <= 1'b1;
							state_r  <= irq_power_pkg::ST_REG_ACK;
						end
						else
						begin
							wr_data_r <= shift_r;
							wr_stb_r  <= 1'b1;
							sda_oe_r  <= 1'b1;
							state_r   <= irq_power_pkg::ST_WDATA_ACK;
						end
					end
				end
				irq_power_pkg::ST_ADDR_ACK, irq_power_pkg::ST_RDATA_NXT:
				begin
					if (scl_fall && (rw_r || state_r == irq_power_pkg::ST_RDATA_NXT))
					begin
						shift_r  <= i_rd_data;
						sda_oe_r <= ~i_rd_data[7];
						bits_r   <= 4'h0;
						state_r  <= irq_power_pkg::ST_RDATA;
					end
					else if (scl_fall)
					begin
						sda_oe_r <= 1'b0;
						state_r  <= irq_power_pkg::ST_REG;
					end
				end
				irq_power_pkg::ST_REG_ACK, irq_power_pkg::ST_WDATA_ACK:
				begin
					if (scl_fall)
					begin
						sda_oe_r <= 1'b0;
						bits_r   <= 4'h0;
						state_r  <= irq_power_pkg::ST_WDATA;
						if (state_r == irq_power_pkg::ST_WDATA_ACK)
							addr_r <= addr_r + 8'h01;
					end
				end
				irq_power_pkg::ST_RDATA:
				begin
					if (scl_rise)
						bits_r <= bits_r + 4'h1;
					else if (scl_fall && byte_done)
					begin
						sda_oe_r <= 1'b0;
						state_r  <= irq_power_pkg::ST_RDATA_ACK;
					end
					else if (scl_fall)
					begin
						sda_oe_r <= ~shift_r[6];
						shift_r  <= {shift_r[6:0], 1'b0};
					end
				end
				irq_power_pkg::ST_RDATA_ACK:
				begin
					// a master nack ends the read; ack moves the pointer on
					if (scl_rise && i_sda)
						state_r <= irq_power_pkg::ST_IDLE;
					else if (scl_rise)
					begin
						addr_r  <= addr_r + 8'h01;
						state_r <= irq_power_pkg::ST_RDATA_NXT;
					end
				end
				default:
					state_r <= irq_power_pkg::ST_IDLE;
				endcase
			end
		end
	end

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	a_write_strobe_ack: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		o_wr_stb |-> o_sda_oe && state_r == irq_power_pkg::ST_WDATA_ACK)
		else $error("write strobe without data acknowledge");

	a_idle_released: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		state_r == irq_power_pkg::ST_IDLE |-> !o_sda_oe)
		else $error("sda held while idle");

endmodule

// [irq_mask_and_power_control.sv]
/*
 * Event, interrupt mask and power control register bank of a power
 * management device, with its two-wire control port.
 * Assumes event pulses, pins and sequencer status are synchronous to
 * i_ref_clk and that the sequencer acts on the target and mode outputs.
 */
`timescale 1ns/1ns
`include "irq_power_params.svh"

// What this block does
// - interrupt low when unmasked event bit set, outside power-up
// - writing ones clears those event bits
// - interrupt held until all unmasked events cleared or power-up begins
// - core mask bits: sequencer, adc, key
// - supply mask bits seven to zero
// - low input masks, bits 0-2 analog too
// - high input masks, two-wire and pins
// - protect bits freeze domain targets on write
// - standby bit picks partial or full shutdown
// - domain targets from reset, host, pins
// - soft start bit drives converters
// - key lock gates wake, cleared on power-up
// - reset output before shutdown, conditional release
// - watchdog halts in sleep unless enabled
// - charger select steers wake detection

module irq_mask_and_power_control #(
	parameter logic [6:0] DEVICE_ADDR = `I2C_DEVICE_ADDR
) (
	input  wire logic       i_ref_clk,               // 100 MHz clock
	input  wire logic       i_reset,                 // async reset, high
	input  wire logic       i_scl,                   // bus clock level
	input  wire logic       i_sda,                   // bus data level
	output logic            o_sda_out,               // sda drive level
	output logic            o_sda_oe,                // sda pull enable
	input  wire logic [7:0] i_event_core,            // core event pulses
	input  wire logic [7:0] i_event_supply,          // supply event pulses
	input  wire logic [7:0] i_event_inputs_low,      // input 0-7 pulses
	input  wire logic [7:0] i_event_inputs_high,     // input 8-15 pulses
	input  wire logic       i_powerup_active,        // power-up running
	input  wire logic       i_secondary_domain_pin,  // domain pin level
	input  wire logic       i_main_domain_pin,       // domain pin level
	input  wire logic       i_system_domain_pin,     // domain pin level
	input  wire logic       i_power_key_input_n,     // key, low pressed
	input  wire logic       i_key_delay_elapsed,     // key held long
	input  wire logic       i_in_sleep,              // in power-down
	input  wire logic       i_powerdown_start,       // shutdown begins
	input  wire logic       i_leave_sleep,           // power-down left
	input  wire logic [1:0] i_reset_event_setting,   // reset event code
	input  wire logic       i_charger_wake_input,    // charger wake pin
	output logic            o_host_interrupt_line_n, // interrupt, low
	output logic            o_secondary_domain_target, // target state
	output logic            o_main_domain_target,    // target state
	output logic            o_system_domain_target,  // target state
	output logic            o_system_shutdown_req,   // pulse, system off
	output logic            o_partial_shutdown_pointer, // stop partial
	output logic            o_converter_soft_start,  // buck soft start
	output logic            o_key_wake_lock,         // lock active
	output logic            o_half_current_sleep,    // low power sleep
	output logic            o_key_wake_request,      // wake by key
	output logic            o_system_reset_output_n, // reset, low
	output logic            o_watchdog_run,          // watchdog runs
	output logic            o_charger_input_select   // wake source
);

	// ------------------------------------------------------------------
	// control port
	// ------------------------------------------------------------------
	logic       wr_stb;
	logic [7:0] reg_addr;
	logic [7:0] wr_data;
	logic [7:0] rd_data;

	i2c_register_port #(
		.DEVICE_ADDR (DEVICE_ADDR)
	) u_port (
		.i_ref_clk  (i_ref_clk),
		.i_reset    (i_reset),
		.i_scl      (i_scl),
		.i_sda      (i_sda),
		.o_sda_out  (o_sda_out),
		.o_sda_oe   (o_sda_oe),
		.o_wr_stb   (wr_stb),
		.o_reg_addr (reg_addr),
		.o_wr_data  (wr_data),
		.i_rd_data  (rd_data)
	);

	// ------------------------------------------------------------------
	// storage
	// ------------------------------------------------------------------
	logic [7:0] event_r [4];
	logic [7:0] mask_r  [4];
	logic [7:0] pdc_r;
	logic [7:0] sbc_r;
	logic [2:0] pin_r;
	logic       chg_r;
	logic       irq_n_r;
	logic       shut_req_r;
	logic       rst_n_r;
	logic       wake_req_r;
	logic       wdog_r;

	// ------------------------------------------------------------------
	// decode
	// ------------------------------------------------------------------
	wire pdc_wr = wr_stb && (reg_addr == `OFS_POWER_DOMAIN_CTRL);
	wire sbc_wr = wr_stb && (reg_addr == `OFS_SYSTEM_BEHAV_CTRL);

	// the wake edge polarity follows the selected source
	wire chg_rise   = i_charger_wake_input & ~chg_r;
	wire chg_fall   = ~i_charger_wake_input & chg_r;
	wire chg_detect = sbc_r[`BIT_CHARGER_SELECT] ? chg_fall : chg_rise;

	wire [7:0] supply_set = i_event_supply | {7'h00, chg_detect};
	wire [7:0] set_vec [4];
	assign set_vec[0] = i_event_core & `CORE_USED_BITS;
	assign set_vec[1] = supply_set;
	assign set_vec[2] = i_event_inputs_low;
	assign set_vec[3] = i_event_inputs_high;

	wire [3:0] unmasked;
	wire [7:0] event_nxt [4];
	wire [7:0] mask_nxt  [4];

	// per event register: write-one clear, set wins, mask stored
	genvar g;
	generate
		for (g = 0; g < 4; g++)
		begin : g_event
			wire ev_wr = wr_stb && (reg_addr == (`OFS_EVENT_CORE + 8'(g)));
			wire mk_wr = wr_stb && (reg_addr == (`OFS_IRQ_MASK_CORE + 8'(g)));
			wire [7:0] used = (g == 0) ? `CORE_USED_BITS : 8'hFF;
			assign event_nxt[g] = (event_r[g] & ~(ev_wr ? wr_data : 8'h00))
			                      | set_vec[g];
			assign mask_nxt[g]  = mk_wr ? (wr_data & used) : mask_r[g];
			assign unmasked[g]  = |(event_r[g] & ~mask_r[g]);
		end
	endgenerate

	wire [7:0] core_view = {|{event_r[3], event_r[2], event_r[1]},
	                        |{event_r[2], event_r[1]}, |event_r[1], event_r[0][4:0]};

	// write-protect bits taken from the same write that carries targets
	wire [2:0] domain_pin  = {i_secondary_domain_pin, i_main_domain_pin,
	                          i_system_domain_pin};
	wire [2:0] pin_change  = domain_pin ^ pin_r;
	wire [2:0] host_target = pdc_wr ? ((wr_data[2:0] & ~wr_data[6:4])
	                         | (pdc_r[2:0] & wr_data[6:4])) : pdc_r[2:0];
	wire [2:0] target_nxt  = (host_target & ~pin_change)
	                         | (domain_pin & pin_change);
	wire [7:0] pdc_nxt     = {1'b0, pdc_wr ? wr_data[6:3] : pdc_r[6:3], target_nxt};

	// hardware clear of the key lock during power-up beats a host write
	wire [7:0] sbc_w   = sbc_wr ? (wr_data & `SBC_USED_BITS) : sbc_r;
	wire [7:0] sbc_nxt = sbc_w & ~({7'h00, i_powerup_active} << `BIT_KEY_LOCK);

	wire sys_off = pdc_r[`BIT_SYSTEM_TARGET] & ~pdc_nxt[`BIT_SYSTEM_TARGET];
	wire release_ok = (i_reset_event_setting < `RESET_EVENT_NO_REL);
	wire key_ok = sbc_r[`BIT_KEY_LOCK] ? i_key_delay_elapsed : 1'b1;

	// ------------------------------------------------------------------
	// read mux
	// ------------------------------------------------------------------
	assign rd_data = (reg_addr == `OFS_EVENT_CORE)        ? core_view :
	                 (reg_addr == `OFS_EVENT_SUPPLY)      ? event_r[1] :
	                 (reg_addr == `OFS_EVENT_INPUTS_LOW)  ? event_r[2] :
	                 (reg_addr == `OFS_EVENT_INPUTS_HIGH) ? event_r[3] :
	                 (reg_addr == `OFS_IRQ_MASK_CORE)     ? mask_r[0] :
	                 (reg_addr == `OFS_IRQ_MASK_SUPPLY)   ? mask_r[1] :
	                 (reg_addr == `OFS_IRQ_MASK_IN_LOW)   ? mask_r[2] :
	                 (reg_addr == `OFS_IRQ_MASK_IN_HIGH)  ? mask_r[3] :
	                 (reg_addr == `OFS_POWER_DOMAIN_CTRL) ? pdc_r :
	                 (reg_addr == `OFS_SYSTEM_BEHAV_CTRL) ? sbc_r : 8'h00;

	// ------------------------------------------------------------------
	// registers
	// ------------------------------------------------------------------
	// events and masks
	always_ff @(posedge i_ref_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			for (int i = 0; i < 4; i++)
			begin
				event_r[i] <= 8'h00;
				mask_r[i]  <= `RST_IRQ_MASK;
			end
		end
		else
		begin
			for (int i = 0; i < 4; i++)
			begin
				event_r[i] <= event_nxt[i];
				mask_r[i]  <= mask_nxt[i];
			end
		end
	end

	// controls and pin history
	always_ff @(posedge i_ref_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			pdc_r <= `RST_POWER_DOMAIN_CTRL;
			sbc_r <= `RST_SYSTEM_BEHAV_CTRL;
			pin_r <= 3'h0;
			chg_r <= 1'b0;
		end
		else
		begin
			pdc_r <= pdc_nxt;
			sbc_r <= sbc_nxt;
			pin_r <= domain_pin;
			chg_r <= i_charger_wake_input;
		end
	end

	// interrupt line, held off during power-up
	always_ff @(posedge i_ref_clk or posedge i_reset)
	begin
		if (i_reset)
			irq_n_r <= 1'b1;
		else
			irq_n_r <= ~((|unmasked) & ~i_powerup_active);
	end

	// sequencer requests
	always_ff @(posedge i_ref_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			shut_req_r <= 1'b0;
			rst_n_r    <= 1'b1;
			wake_req_r <= 1'b0;
			wdog_r     <= 1'b1;
		end
		else
		begin
			shut_req_r <= sys_off;
			if (i_powerdown_start && sbc_r[`BIT_RESET_MODE])
				rst_n_r <= 1'b0;
			else if (i_leave_sleep && release_ok)
				rst_n_r <= 1'b1;
			wake_req_r <= i_in_sleep & ~i_power_key_input_n & key_ok;
			wdog_r     <= ~i_in_sleep | sbc_r[`BIT_WATCHDOG_SLEEP];
		end
	end

	assign o_host_interrupt_line_n    = irq_n_r;
	assign o_secondary_domain_target  = pdc_r[2];
	assign o_main_domain_target       = pdc_r[1];
	assign o_system_domain_target     = pdc_r[`BIT_SYSTEM_TARGET];
	assign o_system_shutdown_req      = shut_req_r;
	assign o_partial_shutdown_pointer = pdc_r[`BIT_STANDBY];
	assign o_converter_soft_start     = sbc_r[`BIT_SOFT_START];
	assign o_key_wake_lock            = sbc_r[`BIT_KEY_LOCK];
	assign o_half_current_sleep       = ~sbc_r[`BIT_KEY_LOCK];
	assign o_key_wake_request         = wake_req_r;
	assign o_system_reset_output_n    = rst_n_r;
	assign o_watchdog_run             = wdog_r;
	assign o_charger_input_select     = sbc_r[`BIT_CHARGER_SELECT];

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	a_irq_follows_events: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		((|unmasked) && !i_powerup_active) |=> !o_host_interrupt_line_n)
		else $error("interrupt not raised for unmasked event");

	a_irq_held_set: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(!o_host_interrupt_line_n && (|unmasked) && !i_powerup_active)
		|=> !o_host_interrupt_line_n)
		else $error("interrupt released with events pending");

	a_clear_exact_bits: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(wr_stb && reg_addr == `OFS_EVENT_SUPPLY && set_vec[1] == 8'h00)
		|=> event_r[1] == ($past(event_r[1]) & ~$past(wr_data)))
		else $error("event clear touched wrong bits");

	// masked core events must still land in their event bits
	a_masked_recorded: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(|(set_vec[0] & mask_r[0]))
		|=> ((event_r[0] & $past(set_vec[0])) == $past(set_vec[0])))
		else $error("masked event not recorded");

	a_protect_target: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(pdc_wr && wr_data[`BIT_PROTECT_SYSTEM] && !pin_change[0])
		|=> o_system_domain_target == $past(o_system_domain_target))
		else $error("protected system target changed");

	a_shutdown_pulse: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		$fell(o_system_domain_target) |-> o_system_shutdown_req)
		else $error("no shutdown request on system target fall");

	a_key_lock_clear: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		i_powerup_active |=> !o_key_wake_lock)
		else $error("key lock not cleared by power-up");

	a_reset_assert: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(i_powerdown_start && sbc_r[`BIT_RESET_MODE]) |=> !o_system_reset_output_n)
		else $error("reset output not asserted before shutdown");

	// only a leave-sleep pulse may lift the reset output again
	a_reset_held: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(!o_system_reset_output_n && !i_leave_sleep) |=> !o_system_reset_output_n)
		else $error("reset output released without leave-sleep");

	a_watchdog_sleep: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(i_in_sleep && !sbc_r[`BIT_WATCHDOG_SLEEP]) |=> !o_watchdog_run)
		else $error("watchdog ran in sleep while disabled");

	a_charger_edge: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(o_charger_input_select && chg_fall) |=> event_r[1][`BIT_SUPPLY_WAKE])
		else $error("charger wake edge missed");

endmodule

// [irq_mask_and_power_control_tb_top.sv]
/*
 * Self-checking bench for the mask and power control bank.
 * Assumes the host model above and the design's default bus address.
 */
`timescale 1ns/1ns

module irq_mask_and_power_control_tb_top;
	logic        clk   = 1'b0;
	logic        rst   = 1'b1;
	logic [31:0] ev    = 32'h0;
	logic        dpin  = 1'b0;
	logic        pwrup = 1'b0;
	logic        slp   = 1'b0;
	logic        pd    = 1'b0;
	logic        lv    = 1'b0;
	logic        key_n = 1'b1;
	logic        kdly  = 1'b0;
	logic        chg   = 1'b0;
	logic [1:0]  rsev  = 2'h0;
	wire         scl, sda, oe, irq_n, t2, t1, t0, pp, ss, kl, hc, rn, wd, cs, sreq, wreq;
	int          n_fail = 0;
	int          compares = 0;
	always #5 clk = ~clk;
	i2c_host_model host_u (.i_ref_clk(clk), .i_sda_oe(oe), .o_scl(scl), .o_sda(sda));
	irq_mask_and_power_control dut_u (.i_ref_clk(clk), .i_reset(rst), .i_scl(scl),
		.i_sda(sda), .o_sda_out(), .o_sda_oe(oe), .i_event_core(ev[31:24]),
		.i_event_supply(ev[23:16]), .i_event_inputs_low(ev[15:8]),
		.i_event_inputs_high(ev[7:0]), .i_powerup_active(pwrup),
		.i_secondary_domain_pin(dpin), .i_main_domain_pin(dpin),
		.i_system_domain_pin(dpin), .i_power_key_input_n(key_n),
		.i_key_delay_elapsed(kdly), .i_in_sleep(slp), .i_powerdown_start(pd),
		.i_leave_sleep(lv), .i_reset_event_setting(rsev), .i_charger_wake_input(chg),
		.o_host_interrupt_line_n(irq_n), .o_secondary_domain_target(t2),
		.o_main_domain_target(t1), .o_system_domain_target(t0),
		.o_system_shutdown_req(sreq), .o_partial_shutdown_pointer(pp),
		.o_converter_soft_start(ss), .o_key_wake_lock(kl), .o_half_current_sleep(hc),
		.o_key_wake_request(wreq), .o_system_reset_output_n(rn), .o_watchdog_run(wd),
		.o_charger_input_select(cs));
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		compares++;
		if (g !== e)
		begin
			n_fail++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] q;
		host_u.rd(a, q);
		chk("register", e, q);
	endtask
	// events last one cycle, then settle three edges before checking
	task automatic pulse(input logic [31:0] v);
		ev <= v;
		tick(1);
		ev <= 32'h0;
		tick(3);
	endtask
	task automatic close_out();
		if (n_fail == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial
	begin
		tick(20);
		rst <= 1'b0;
		tick(2);
		chk("irq_n", 8'h01, {7'h00, irq_n});
		rdchk(8'h0E, 8'h00);
		host_u.wr(8'h0A, 8'h19);
		pulse(32'h1900_0000);
		chk("irq_n masked", 8'h01, {7'h00, irq_n});
		rdchk(8'h06, 8'h19);
		host_u.wr(8'h0A, 8'h11);
		tick(2);
		chk("irq_n unmasked", 8'h00, {7'h00, irq_n});
		host_u.wr(8'h06, 8'h19);
		chk("irq_n cleared", 8'h01, {7'h00, irq_n});
		host_u.wr(8'h0B, 8'hFE);
		pulse(32'h0001_0440);
		chk("irq_n three", 8'h00, {7'h00, irq_n});
		rdchk(8'h06, 8'hE0);
		host_u.wr(8'h07, 8'h01);
		host_u.wr(8'h08, 8'h04);
		chk("irq_n held", 8'h00, {7'h00, irq_n});
		host_u.wr(8'h09, 8'h40);
		chk("irq_n released", 8'h01, {7'h00, irq_n});
		host_u.wr(8'h0E, 8'h1F);
		chk("targets", 8'h0E, {4'h0, pp, t2, t1, t0});
		rdchk(8'h0E, 8'h1E);
		dpin <= 1'b1;
		tick(2);
		chk("pin targets", 8'h07, {5'h00, t2, t1, t0});
		// pins dropping takes the system target down and asks for shutdown
		dpin <= 1'b0;
		tick(2);
		chk("shutdown req", 8'h01, {7'h00, sreq});
		chk("pins off", 8'h08, {4'h0, pp, t2, t1, t0});
		host_u.wr(8'h0F, 8'h97);
		rdchk(8'h0F, 8'h97);
		chk("control b", 8'h0D, {4'h0, ss, kl, hc, cs});
		// safe-out source: only the falling edge records a wake event
		chg <= 1'b1;
		tick(3);
		rdchk(8'h07, 8'h00);
		chg <= 1'b0;
		tick(3);
		rdchk(8'h07, 8'h01);
		host_u.wr(8'h07, 8'h01);
		slp <= 1'b1;
		pd <= 1'b1;
		tick(1);
		pd <= 1'b0;
		tick(2);
		chk("reset low", 8'h00, {7'h00, rn});
		chk("watchdog on", 8'h01, {7'h00, wd});
		key_n <= 1'b0;
		tick(2);
		chk("key wake locked", 8'h00, {7'h00, wreq});
		kdly <= 1'b1;
		tick(2);
		chk("key wake", 8'h01, {7'h00, wreq});
		key_n <= 1'b1;
		lv <= 1'b1;
		pwrup <= 1'b1;
		tick(1);
		lv <= 1'b0;
		pwrup <= 1'b0;
		tick(2);
		chk("reset high", 8'h01, {7'h00, rn});
		chk("key lock", 8'h00, {7'h00, kl});
		// reset event code 3 keeps the reset output low after sleep
		rsev <= 2'h3;
		pd <= 1'b1;
		tick(1);
		pd <= 1'b0;
		lv <= 1'b1;
		tick(1);
		lv <= 1'b0;
		tick(2);
		chk("reset kept", 8'h00, {7'h00, rn});
		host_u.wr(8'h0F, 8'h00);
		chk("watchdog off", 8'h00, {7'h00, wd});
		close_out();
	end
endmodule

// [irq_power_params.svh]
/*
 * Offsets, field positions, reset values and address constants for the
 * interrupt mask and power control register bank.
 * Assumes an 8-bit register space reached over the two-wire control port.
 */
`ifndef IRQ_POWER_PARAMS_SVH
`define IRQ_POWER_PARAMS_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define OFS_EVENT_CORE        8'h06
`define OFS_EVENT_SUPPLY      8'h07
`define OFS_EVENT_INPUTS_LOW  8'h08
`define OFS_EVENT_INPUTS_HIGH 8'h09
`define OFS_IRQ_MASK_CORE     8'h0A
`define OFS_IRQ_MASK_SUPPLY   8'h0B
`define OFS_IRQ_MASK_IN_LOW   8'h0C
`define OFS_IRQ_MASK_IN_HIGH  8'h0D
`define OFS_POWER_DOMAIN_CTRL 8'h0E
`define OFS_SYSTEM_BEHAV_CTRL 8'h0F

// ----------------------------------------------------------------------
// implemented bits and reset values
// ----------------------------------------------------------------------
`define CORE_USED_BITS        8'h19
`define PDC_USED_BITS         8'h7F
`define SBC_USED_BITS         8'h97
`define RST_IRQ_MASK          8'h00
`define RST_POWER_DOMAIN_CTRL 8'h00
`define RST_SYSTEM_BEHAV_CTRL 8'h00

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define BIT_EVENTS_HIGH       7
`define BIT_EVENTS_LOW        6
`define BIT_EVENTS_SUPPLY     5
`define BIT_SUPPLY_WAKE       0
`define BIT_PROTECT_SYSTEM    4
`define BIT_STANDBY           3
`define BIT_SYSTEM_TARGET     0
`define BIT_SOFT_START        7
`define BIT_KEY_LOCK          4
`define BIT_RESET_MODE        2
`define BIT_WATCHDOG_SLEEP    1
`define BIT_CHARGER_SELECT    0
`define RESET_EVENT_NO_REL    2'h3

// ----------------------------------------------------------------------
// control port
// ----------------------------------------------------------------------
`define I2C_DEVICE_ADDR       7'h58
`define I2C_LOWEST_ADDR       7'h08
`define I2C_BYTE_BITS         4'h8

`endif

// [irq_power_pkg.sv]
/*
 * Types used by the two-wire control port of the register bank.
 * Assumes nothing beyond a SystemVerilog package scope.
 */
package irq_power_pkg;

	// one-hot states of the two-wire slave
	typedef enum logic [9:0] {
		ST_IDLE      = 10'h001,
		ST_ADDR      = 10'h002,
		ST_ADDR_ACK  = 10'h004,
		ST_REG       = 10'h008,
		ST_REG_ACK   = 10'h010,
		ST_WDATA     = 10'h020,
		ST_WDATA_ACK = 10'h040,
		ST_RDATA     = 10'h080,
		ST_RDATA_ACK = 10'h100,
		ST_RDATA_NXT = 10'h200
	} i2c_state_t;

endpackage
